//--- inc/bdc_defines.vh
// debug port constants
`ifndef BDC_DEFINES_VH
`define BDC_DEFINES_VH

// ----------------------------------------------------------------
// timing, in debug clock cycles
// ----------------------------------------------------------------
`define BDC_BIT_CYCLES 5'd16
`define BDC_RX_SAMPLE 5'd10
`define BDC_TX_ZERO_LOW 5'd13
`define BDC_TX_ONE_PULSE 5'd7
`define BDC_TIMEOUT 11'd512
`define BDC_DELAY_SLOT 8'd16
`define BDC_EXEC_MIN 8'd4
`define BDC_SYNC_DETECT 8'd64
`define BDC_SYNC_GAP 8'd16
`define BDC_SYNC_LOW 8'd128

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define BDC_OP_ACK_ON 8'hD5
`define BDC_OP_ACK_OFF 8'hD6
`define BDC_OP_BGND 8'h90
`define BDC_OP_RD_STAT 8'hE4
`define BDC_OP_WR_CTRL 8'hC4
`define BDC_OP_RD_MEM 8'hE0
`define BDC_OP_RD_MEM_WS 8'hE1
`define BDC_OP_RD_LAST 8'hE8
`define BDC_OP_WR_MEM 8'hC0
`define BDC_OP_WR_MEM_WS 8'hC1
`define BDC_OP_RD_MATCH 8'hE2
`define BDC_OP_WR_MATCH 8'hC2
`define BDC_OP_GO 8'h08
`define BDC_OP_STEP 8'h10
`define BDC_OP_TAG_GO 8'h18
`define BDC_OP_RD_A 8'h68
`define BDC_OP_RD_CC 8'h69
`define BDC_OP_RD_PC 8'h6B
`define BDC_OP_RD_HX 8'h6C
`define BDC_OP_RD_SP 8'h6F
`define BDC_OP_RD_NEXT 8'h70
`define BDC_OP_RD_NEXT_WS 8'h71
`define BDC_OP_WR_A 8'h48
`define BDC_OP_WR_CC 8'h49
`define BDC_OP_WR_PC 8'h4B
`define BDC_OP_WR_HX 8'h4C
`define BDC_OP_WR_SP 8'h4F
`define BDC_OP_WR_NEXT 8'h50
`define BDC_OP_WR_NEXT_WS 8'h51

// ----------------------------------------------------------------
// status/control byte layout and resets
// ----------------------------------------------------------------
`define BDC_SC_BGEN 7
`define BDC_SC_BGND 6
`define BDC_SC_ACK 2
`define BDC_SC_WMASK 8'hB8
`define BDC_SC_RESET 8'h00
`define BDC_MATCH_RESET 16'h0000
`define BDC_SEL_HX 3'h4

`endif

//--- hdl/bdc_bit_engine.v
// bit timing of the debug pin
`timescale 1ns/1ps
`include "bdc_defines.vh"

module bdc_bit_engine (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // pin level and transmit request
  input wire pin_in,
  input wire tx_en,
  input wire tx_bit,
  // bit results
  output reg bit_stb,
  output reg bit_val,
  output reg timeout_stb,
  // drive requests, registered by the caller
  output wire drv_low,
  output wire drv_high
);

  reg pin_prev_reg;
  reg act_reg;
  reg txm_reg;
  reg txb_reg;
  reg [4:0] cnt_reg;
  reg [10:0] idle_reg;
  wire fall;

  assign fall = pin_prev_reg & ~pin_in;

  // ----------------------------------------------------------------
  // bit counter, restarted by each host edge
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_prev_reg <= 1'b1;
      act_reg <= 1'b0;
      txm_reg <= 1'b0;
      txb_reg <= 1'b1;
      cnt_reg <= 5'h00;
      bit_stb <= 1'b0;
      bit_val <= 1'b1;
      idle_reg <= 11'h000;
      timeout_stb <= 1'b0;
    end else begin
      pin_prev_reg <= pin_in;
      bit_stb <= act_reg & (cnt_reg == (`BDC_RX_SAMPLE - 5'd1));
      bit_val <= pin_in;
      if (fall) begin
        act_reg <= 1'b1;
        cnt_reg <= 5'h00;
        txm_reg <= tx_en;
        txb_reg <= tx_bit;
      end else if (act_reg) begin
        cnt_reg <= cnt_reg + 5'd1;
        if (cnt_reg == (`BDC_BIT_CYCLES - 5'd1)) begin
          act_reg <= 1'b0;
        end
      end
      // saturating count since the last host edge
      if (fall) begin
        idle_reg <= 11'h000;
      end else if (idle_reg != `BDC_TIMEOUT) begin
        idle_reg <= idle_reg + 11'd1;
      end
      timeout_stb <= ~fall & (idle_reg == (`BDC_TIMEOUT - 11'd1));
    end
  end

  // ----------------------------------------------------------------
  // caller registers these; offsets absorb the stage
  // ----------------------------------------------------------------
  assign drv_low = (fall & tx_en & ~tx_bit) |
    (act_reg & txm_reg & ~txb_reg & (cnt_reg < (`BDC_TX_ZERO_LOW - 5'd2)));
  assign drv_high = act_reg & txm_reg &
    (cnt_reg == (txb_reg ? (`BDC_TX_ONE_PULSE - 5'd2) : (`BDC_TX_ZERO_LOW - 5'd2)));

endmodule // bdc_bit_engine

//--- hdl/bdc_serial_port.v
// debug command layer
`timescale 1ns/1ps
`include "bdc_defines.vh"

module bdc_serial_port (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // debug pin, pseudo open drain
  input wire debug_pin_in,
  output reg debug_pin_out,
  output reg debug_pin_oe,
  // target memory
  output reg mem_req,
  output reg mem_we,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  // cpu
  input wire cpu_in_background,
  input wire [7:0] cpu_a,
  input wire [7:0] cpu_ccr,
  input wire [15:0] cpu_pc,
  input wire [15:0] cpu_hx,
  input wire [15:0] cpu_sp,
  output reg cpu_wr,
  output reg [2:0] cpu_reg_sel,
  output reg [15:0] cpu_wdata,
  output reg cpu_go,
  output reg cpu_step,
  output reg cpu_bgnd_req,
  // control state
  output reg [15:0] breakpoint_match,
  output reg [7:0] debug_status_control,
  output reg ack_enable
);

  // ----------------------------------------------------------------
  // states and command flags
  // ----------------------------------------------------------------
  localparam [9:0] ST_IDLE = 10'h001;
  localparam [9:0] ST_ADDR = 10'h002;
  localparam [9:0] ST_WDATA = 10'h004;
  localparam [9:0] ST_EXEC = 10'h008;
  localparam [9:0] ST_SS = 10'h010;
  localparam [9:0] ST_RDATA = 10'h020;
  localparam [9:0] ST_SWAIT = 10'h040;
  localparam [9:0] ST_SGAP = 10'h080;
  localparam [9:0] ST_SLOW = 10'h100;
  localparam [9:0] ST_SHI = 10'h200;

  localparam F_KNOWN = 9;
  localparam F_BGND = 8;
  localparam F_ADDR = 7;
  localparam F_W8 = 6;
  localparam F_W16 = 5;
  localparam F_DLY = 4;
  localparam F_SS = 3;
  localparam F_R8 = 2;
  localparam F_R16 = 1;
  localparam F_HX = 0;

  // field layout of each opcode
  function [9:0] cmd_flags;
    input [7:0] op;
    begin
      case (op)
        `BDC_OP_ACK_ON, `BDC_OP_ACK_OFF, `BDC_OP_BGND: cmd_flags = 10'h210;
        `BDC_OP_RD_STAT: cmd_flags = 10'h208;
        `BDC_OP_WR_CTRL: cmd_flags = 10'h240;
        `BDC_OP_RD_MEM: cmd_flags = 10'h294;
        `BDC_OP_RD_MEM_WS: cmd_flags = 10'h29C;
        `BDC_OP_RD_LAST: cmd_flags = 10'h20C;
        `BDC_OP_WR_MEM: cmd_flags = 10'h2D0;
        `BDC_OP_WR_MEM_WS: cmd_flags = 10'h2D8;
        `BDC_OP_RD_MATCH: cmd_flags = 10'h202;
        `BDC_OP_WR_MATCH: cmd_flags = 10'h220;
        `BDC_OP_GO, `BDC_OP_STEP, `BDC_OP_TAG_GO: cmd_flags = 10'h310;
        `BDC_OP_RD_A, `BDC_OP_RD_CC: cmd_flags = 10'h314;
        `BDC_OP_RD_PC, `BDC_OP_RD_HX, `BDC_OP_RD_SP: cmd_flags = 10'h312;
        `BDC_OP_RD_NEXT: cmd_flags = 10'h315;
        `BDC_OP_RD_NEXT_WS: cmd_flags = 10'h31D;
        `BDC_OP_WR_A, `BDC_OP_WR_CC: cmd_flags = 10'h350;
        `BDC_OP_WR_PC, `BDC_OP_WR_HX, `BDC_OP_WR_SP: cmd_flags = 10'h330;
        `BDC_OP_WR_NEXT: cmd_flags = 10'h351;
        `BDC_OP_WR_NEXT_WS: cmd_flags = 10'h359;
        default: cmd_flags = 10'h000;
      endcase
    end
  endfunction

  // phase after stage stg: addr, wdata, exec, status, data
  function [9:0] next_phase;
    input [2:0] stg;
    input [9:0] f;
    begin
      if (stg < 3'd1 && f[F_ADDR])
        next_phase = ST_ADDR;
      else if (stg < 3'd2 && (f[F_W8] | f[F_W16]))
        next_phase = ST_WDATA;
      else if (stg < 3'd3)
        next_phase = ST_EXEC;
      else if (stg < 3'd4 && f[F_SS])
        next_phase = ST_SS;
      else if (stg < 3'd5 && (f[F_R8] | f[F_R16]))
        next_phase = ST_RDATA;
      else
        next_phase = ST_IDLE;
    end
  endfunction

  reg [9:0] state_reg;
  reg [9:0] flags_reg;
  reg [7:0] op_reg;
  reg [15:0] sr_reg;
  reg [3:0] bcnt_reg;
  reg [7:0] dcnt_reg;
  reg [7:0] low_reg;
  reg [15:0] addr_reg;
  reg [15:0] wd_reg;
  reg [15:0] rd_reg;
  reg [15:0] last_reg;
  reg rd_pend_reg;
  reg rd_cap_reg;
  reg allow_reg;

  wire bit_stb;
  wire bit_val;
  wire timeout_stb;
  wire drv_low;
  wire drv_high;
  wire in_sync;
  wire tx_phase;
  wire [9:0] new_flags;
  wire [15:0] shifted;
  wire [3:0] last_bit;
  wire [15:0] hx_inc;
  wire [7:0] status_byte;
  wire [7:0] exec_end;

  assign in_sync = |(state_reg & (ST_SWAIT | ST_SGAP | ST_SLOW | ST_SHI));
  assign tx_phase = |(state_reg & (ST_SS | ST_RDATA));
  assign shifted = {sr_reg[14:0], bit_val};
  assign new_flags = cmd_flags(shifted[7:0]);
  assign hx_inc = cpu_hx + 16'h0001;
  assign status_byte = (debug_status_control & `BDC_SC_WMASK) |
    ({7'h00, cpu_in_background} << `BDC_SC_BGND) |
    ({7'h00, ack_enable} << `BDC_SC_ACK);
  assign exec_end = flags_reg[F_DLY] ? (`BDC_DELAY_SLOT - 8'd1) : (`BDC_EXEC_MIN - 8'd1);
  assign last_bit = (state_reg == ST_IDLE || state_reg == ST_SS) ? 4'd7 :
    (state_reg == ST_ADDR) ? 4'd15 :
    (state_reg == ST_WDATA) ? (flags_reg[F_W16] ? 4'd15 : 4'd7) :
    (flags_reg[F_R16] ? 4'd15 : 4'd7);

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  bdc_bit_engine u_bit (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(debug_pin_in),
    .tx_en(tx_phase),
    .tx_bit(sr_reg[15]),
    .bit_stb(bit_stb),
    .bit_val(bit_val),
    .timeout_stb(timeout_stb),
    .drv_low(drv_low),
    .drv_high(drv_high)
  );

  // ----------------------------------------------------------------
  // pin driver and long-low detector
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      debug_pin_out <= 1'b1;
      debug_pin_oe <= 1'b0;
      low_reg <= 8'h00;
    end else begin
      if (in_sync) begin
        debug_pin_oe <= (state_reg == ST_SLOW) | (state_reg == ST_SHI);
        debug_pin_out <= (state_reg == ST_SHI);
      end else begin
        debug_pin_oe <= drv_low | drv_high;
        debug_pin_out <= drv_high;
      end
      // own drive must not count as a host probe
      if (debug_pin_in | debug_pin_oe | in_sync)
        low_reg <= 8'h00;
      else if (low_reg != `BDC_SYNC_DETECT)
        low_reg <= low_reg + 8'd1;
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      flags_reg <= 10'h000;
      op_reg <= 8'h00;
      sr_reg <= 16'hFFFF;
      bcnt_reg <= 4'h0;
      dcnt_reg <= 8'h00;
      addr_reg <= 16'h0000;
      wd_reg <= 16'h0000;
      rd_reg <= 16'h0000;
      last_reg <= 16'h0000;
      rd_pend_reg <= 1'b0;
      rd_cap_reg <= 1'b0;
      allow_reg <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      cpu_wr <= 1'b0;
      cpu_reg_sel <= 3'h0;
      cpu_wdata <= 16'h0000;
      cpu_go <= 1'b0;
      cpu_step <= 1'b0;
      cpu_bgnd_req <= 1'b0;
      breakpoint_match <= `BDC_MATCH_RESET;
      debug_status_control <= `BDC_SC_RESET;
      ack_enable <= 1'b0;
    end else begin
      mem_req <= 1'b0;
      cpu_wr <= 1'b0;
      cpu_go <= 1'b0;
      cpu_step <= 1'b0;
      cpu_bgnd_req <= 1'b0;
      // memory data is valid the cycle after the request
      rd_pend_reg <= mem_req & ~mem_we;
      rd_cap_reg <= rd_pend_reg;
      if (rd_pend_reg)
        rd_reg <= {8'h00, mem_rdata};
      if (low_reg == (`BDC_SYNC_DETECT - 8'd1) && !in_sync) begin
        state_reg <= ST_SWAIT;
        bcnt_reg <= 4'h0;
      end else if (timeout_stb && state_reg != ST_EXEC && !in_sync) begin
        state_reg <= ST_IDLE;
        bcnt_reg <= 4'h0;
      end else begin
        case (state_reg)
          ST_IDLE, ST_ADDR, ST_WDATA: begin
            if (bit_stb) begin
              sr_reg <= shifted;
              bcnt_reg <= bcnt_reg + 4'd1;
              if (bcnt_reg == last_bit) begin
                bcnt_reg <= 4'h0;
                dcnt_reg <= 8'h00;
                if (state_reg == ST_IDLE) begin
                  op_reg <= shifted[7:0];
                  flags_reg <= new_flags;
                  // unknown opcodes are dropped
                  state_reg <= new_flags[F_KNOWN] ? next_phase(3'd0, new_flags) : ST_IDLE;
                end else if (state_reg == ST_ADDR) begin
                  addr_reg <= shifted;
                  state_reg <= next_phase(3'd1, flags_reg);
                end else begin
                  wd_reg <= shifted;
                  state_reg <= next_phase(3'd2, flags_reg);
                end
              end
            end
          end
          ST_EXEC: begin
            dcnt_reg <= dcnt_reg + 8'd1;
            if (dcnt_reg == 8'h00) begin
              allow_reg <= ~flags_reg[F_BGND] | cpu_in_background;
              if (!flags_reg[F_BGND] || cpu_in_background) begin
                case (op_reg)
                  `BDC_OP_ACK_ON: ack_enable <= 1'b1;
                  `BDC_OP_ACK_OFF: ack_enable <= 1'b0;
                  `BDC_OP_BGND: cpu_bgnd_req <= debug_status_control[`BDC_SC_BGEN];
                  `BDC_OP_WR_CTRL: debug_status_control <= wd_reg[7:0] & `BDC_SC_WMASK;
                  `BDC_OP_WR_MATCH: breakpoint_match <= wd_reg;
                  `BDC_OP_RD_MATCH: rd_reg <= breakpoint_match;
                  `BDC_OP_RD_MEM, `BDC_OP_RD_MEM_WS: begin
                    mem_req <= 1'b1;
                    mem_we <= 1'b0;
                    mem_addr <= addr_reg;
                    last_reg <= addr_reg;
                  end
                  `BDC_OP_RD_LAST: begin
                    mem_req <= 1'b1;
                    mem_we <= 1'b0;
                    mem_addr <= last_reg;
                  end
                  `BDC_OP_WR_MEM, `BDC_OP_WR_MEM_WS: begin
                    mem_req <= 1'b1;
                    mem_we <= 1'b1;
                    mem_addr <= addr_reg;
                    mem_wdata <= wd_reg[7:0];
                  end
                  `BDC_OP_GO, `BDC_OP_TAG_GO: cpu_go <= 1'b1;
                  `BDC_OP_STEP: cpu_step <= 1'b1;
                  `BDC_OP_RD_A: rd_reg <= {8'h00, cpu_a};
                  `BDC_OP_RD_CC: rd_reg <= {8'h00, cpu_ccr};
                  `BDC_OP_RD_PC: rd_reg <= cpu_pc;
                  `BDC_OP_RD_HX: rd_reg <= cpu_hx;
                  `BDC_OP_RD_SP: rd_reg <= cpu_sp;
                  `BDC_OP_WR_A, `BDC_OP_WR_CC, `BDC_OP_WR_PC, `BDC_OP_WR_HX,
                  `BDC_OP_WR_SP: begin
                    cpu_wr <= 1'b1;
                    cpu_reg_sel <= op_reg[2:0];
                    cpu_wdata <= wd_reg;
                  end
                  `BDC_OP_RD_NEXT, `BDC_OP_RD_NEXT_WS, `BDC_OP_WR_NEXT,
                  `BDC_OP_WR_NEXT_WS: begin
                    cpu_wr <= 1'b1;
                    cpu_reg_sel <= `BDC_SEL_HX;
                    cpu_wdata <= hx_inc;
                    mem_req <= 1'b1;
                    mem_we <= ~op_reg[5];
                    mem_addr <= hx_inc;
                    mem_wdata <= wd_reg[7:0];
                    last_reg <= hx_inc;
                  end
                  default: allow_reg <= allow_reg;
                endcase
              end else begin
                rd_reg <= 16'h0000;
              end
            end
            if (dcnt_reg == exec_end) begin
              state_reg <= next_phase(3'd3, flags_reg);
              sr_reg <= {status_byte, 8'h00};
              if (!flags_reg[F_SS])
                sr_reg <= flags_reg[F_R16] ? rd_reg : {rd_reg[7:0], 8'h00};
            end
          end
          ST_SS, ST_RDATA: begin
            if (bit_stb) begin
              sr_reg <= {sr_reg[14:0], 1'b1};
              bcnt_reg <= bcnt_reg + 4'd1;
              if (bcnt_reg == last_bit) begin
                bcnt_reg <= 4'h0;
                state_reg <= next_phase(state_reg == ST_SS ? 3'd4 : 3'd5, flags_reg);
                if (state_reg == ST_SS)
                  sr_reg <= flags_reg[F_R16] ? rd_reg : {rd_reg[7:0], 8'h00};
              end
            end
          end
          ST_SWAIT: begin
            dcnt_reg <= 8'h00;
            if (debug_pin_in)
              state_reg <= ST_SGAP;
          end
          ST_SGAP: begin
            dcnt_reg <= dcnt_reg + 8'd1;
            if (dcnt_reg == (`BDC_SYNC_GAP - 8'd1)) begin
              dcnt_reg <= 8'h00;
              state_reg <= ST_SLOW;
            end
          end
          ST_SLOW: begin
            dcnt_reg <= dcnt_reg + 8'd1;
            if (dcnt_reg == (`BDC_SYNC_LOW - 8'd1))
              state_reg <= ST_SHI;
          end
          ST_SHI: state_reg <= ST_IDLE;
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // bdc_serial_port

//--- dv/bdc_serial_port_checker.sv
// command port assertions
`timescale 1ns/1ps
module bdc_serial_port_checker (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // debug pin
  input wire debug_pin_in,
  input wire debug_pin_out,
  input wire debug_pin_oe,
  // target side
  input wire mem_req,
  input wire cpu_in_background,
  input wire cpu_wr,
  input wire cpu_go,
  input wire cpu_step,
  input wire cpu_bgnd_req,
  input wire [7:0] debug_status_control
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  wire low_drv = debug_pin_oe && !debug_pin_out;
  reg [7:0] low_cnt_reg;
  reg [9:0] idle_cnt_reg;
  // low-drive length; cycles since host edge
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt_reg <= 8'h00;
      idle_cnt_reg <= 10'h000;
    end else begin
      low_cnt_reg <= low_drv ? low_cnt_reg + 8'h01 : 8'h00;
      if ($fell(debug_pin_in)) begin
        idle_cnt_reg <= 10'h000;
      end else if (idle_cnt_reg != 10'h3FF) begin
        idle_cnt_reg <= idle_cnt_reg + 10'h001;
      end
    end
  end
  property p_low_len;
    $fell(low_drv) |-> (low_cnt_reg == 8'h0C || low_cnt_reg == 8'h80);
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("bad low length");
  property p_pulse_after_low;
    $fell(low_drv) |-> (debug_pin_oe && debug_pin_out) ##1 !debug_pin_oe;
  endproperty
  a_pulse_after_low: assert property (p_pulse_after_low)
    else $error("no speedup pulse");
  property p_pulse_one;
    debug_pin_oe && debug_pin_out |=> !(debug_pin_oe && debug_pin_out);
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("long speedup pulse");
  property p_mem_gap;
    $rose(mem_req) |=> !mem_req [*8];
  endproperty
  a_mem_gap: assert property (p_mem_gap)
    else $error("memory gap short");
  property p_bg_only;
    cpu_go || cpu_step || cpu_wr |-> cpu_in_background;
  endproperty
  a_bg_only: assert property (p_bg_only)
    else $error("action outside background");
  property p_bgnd_en;
    cpu_bgnd_req |-> debug_status_control[7];
  endproperty
  a_bgnd_en: assert property (p_bgnd_en)
    else $error("request not enabled");
  property p_ctrl_bits;
    (debug_status_control & 8'h47) == 8'h00;
  endproperty
  a_ctrl_bits: assert property (p_ctrl_bits)
    else $error("status bits stored");
  property p_one_action;
    cpu_go |-> !cpu_step && !cpu_bgnd_req;
  endproperty
  a_one_action: assert property (p_one_action)
    else $error("two cpu pulses");
  property p_idle_quiet;
    idle_cnt_reg > 10'h040 |-> !mem_req && !cpu_wr && !cpu_go && !cpu_step && !cpu_bgnd_req;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("action after timeout");
endmodule // bdc_serial_port_checker

bind bdc_serial_port bdc_serial_port_checker chk (
  .ref_clk,
  .sys_rst,
  .debug_pin_in,
  .debug_pin_out,
  .debug_pin_oe,
  .mem_req,
  .cpu_in_background,
  .cpu_wr,
  .cpu_go,
  .cpu_step,
  .cpu_bgnd_req,
  .debug_status_control
);

//--- dv/bdc_pod_model.sv
// debug pod model
`timescale 1ns/1ps
module bdc_pod_model (
  // clock
  input wire ref_clk,
  // wire level, and the pod's pull-down
  input wire pin,
  output reg pod_low
);
  initial begin
    pod_low = 1'b0;
  end
  // zero held past the sample point
  task send(input [23:0] v, input integer n);
    integer k;
    begin
      @(negedge ref_clk);
      for (k = n - 1; k >= 0; k = k - 1) begin
        pod_low = 1'b1;
        repeat (v[k] ? 3 : 13) @(negedge ref_clk);
        pod_low = 1'b0;
        repeat (v[k] ? 13 : 3) @(negedge ref_clk);
      end
    end
  endtask
  // released before the speedup pulse
  task recv(output [23:0] r, input integer n);
    integer k;
    begin
      r = 24'h000000;
      @(negedge ref_clk);
      for (k = 0; k < n; k = k + 1) begin
        pod_low = 1'b1;
        repeat (2) @(negedge ref_clk);
        pod_low = 1'b0;
        repeat (8) @(negedge ref_clk);
        r = {r[22:0], pin};
        repeat (6) @(negedge ref_clk);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask
  task sync(output integer gap, output integer len);
    begin
      @(negedge ref_clk);
      pod_low = 1'b1;
      repeat (200) @(negedge ref_clk);
      pod_low = 1'b0;
      #1;
      gap = 0;
      len = 0;
      while (pin === 1'b1) begin
        @(negedge ref_clk);
        gap = gap + 1;
      end
      while (pin === 1'b0) begin
        @(negedge ref_clk);
        len = len + 1;
      end
    end
  endtask
endmodule // bdc_pod_model

//--- dv/test_bdc_command_serial_port.sv
// self-checking bench
`timescale 1ns/1ps
`include "bdc_defines.vh"
module test_bdc_command_serial_port;
  reg ref_clk, sys_rst, cpu_in_background, ack_m;
  wire debug_pin_in, debug_pin_out, debug_pin_oe, mem_req, mem_we, cpu_wr, pod_low;
  wire cpu_go, cpu_step, cpu_bgnd_req, ack_enable;
  wire [15:0] mem_addr, breakpoint_match, cpu_wdata;
  wire [7:0] mem_wdata, debug_status_control;
  wire [2:0] cpu_reg_sel;
  reg [7:0] mem_rdata, cpu_a, cpu_ccr, b, ctrl_m;
  reg [15:0] cpu_pc, cpu_hx, cpu_sp, v;
  reg [7:0] mem [0:255];
  reg [31:0] exp_q [$];
  reg [39:0] rops = {8'h68, 8'h69, 8'h6B, 8'h6C, 8'h6F};
  integer num_errors, checks, seed, i, gap, len;
  // pull-up wire
  assign debug_pin_in = !pod_low && (!debug_pin_oe || debug_pin_out);
  bdc_serial_port dut (.ref_clk, .sys_rst, .debug_pin_in, .debug_pin_out, .debug_pin_oe, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .cpu_in_background, .cpu_a, .cpu_ccr, .cpu_pc,
    .cpu_hx, .cpu_sp, .cpu_wr, .cpu_reg_sel, .cpu_wdata, .cpu_go, .cpu_step, .cpu_bgnd_req,
    .breakpoint_match, .debug_status_control, .ack_enable);
  bdc_pod_model pod (.ref_clk, .pin(debug_pin_in), .pod_low);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (mem_req && mem_we) begin
      mem[mem_addr[7:0]] <= mem_wdata;
    end
  end
  always @(negedge ref_clk) begin
    if (mem_req) begin
      mem_rdata <= mem[mem_addr[7:0]];
    end
  end
  task check_evt(input [31:0] got);
    reg [31:0] e;
    begin
      checks = checks + 1;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hFFFFFFFF;
      if (got !== e) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: event %h, expected %h", $time, got, e);
      end
    end
  endtask
  task chk_val(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: level %h, expected %h", $time, got, exp);
      end
    end
  endtask
  // each write, go, step or bgnd pulse must match the oldest note; memory reads are not checked here
  always @(posedge ref_clk) begin
    if (cpu_wr) check_evt({8'h02, 5'h00, cpu_reg_sel,
      (cpu_reg_sel < 3'h3) ? {8'h00, cpu_wdata[7:0]} : cpu_wdata});
    if (mem_req && mem_we) check_evt({8'h01, mem_addr, mem_wdata});
    if (cpu_go) check_evt(32'h03000000);
    if (cpu_step) check_evt(32'h04000000);
    if (cpu_bgnd_req) check_evt(32'h05000000);
  end
  function [7:0] ss;
    ss = ctrl_m | {1'b0, cpu_in_background, 3'h0, ack_m, 2'h0};
  endfunction
  function [15:0] creg(input [2:0] s);
    creg = (s == 3'h0) ? {8'h00, cpu_a} : (s == 3'h1) ? {8'h00, cpu_ccr} :
      (s == 3'h3) ? cpu_pc : (s == 3'h4) ? cpu_hx : cpu_sp;
  endfunction
  task push(input [31:0] e);
    exp_q.push_back(e);
  endtask
  // opcode, host field, delay, target field
  task cmd(input [7:0] op, input [23:0] hv, input integer hn, input integer dly,
    input integer rn);
    reg [23:0] r;
    begin
      pod.send({16'h0000, op}, 8);
      if (hn > 0) pod.send(hv, hn);
      pod.idle(dly);
      if (rn > 0) begin
        pod.recv(r, rn);
        check_evt({8'h06, r});
      end
      pod.idle(4);
    end
  endtask
  task done(input [63:0] name);
    $display("test %0s finished", name);
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d, num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  // run needs ~12400 cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    num_errors = num_errors + 1;
    $display("wrong value at %0t: run hung", $time);
    tally_and_finish;
  end
  initial begin
    seed = 72;
    num_errors = 0;
    checks = 0;
    sys_rst = 1'b1;
    cpu_in_background = 1'b1;
    mem_rdata = 8'h00;
    cpu_a = $random(seed);
    cpu_ccr = $random(seed);
    cpu_pc = $random(seed);
    cpu_hx = $random(seed);
    cpu_sp = $random(seed);
    ctrl_m = 8'h00;
    ack_m = 1'b0;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk_val({debug_pin_oe, ack_enable, debug_status_control, breakpoint_match}, 32'h0);
    pod.idle(2);
    done("reset");
    v = $random(seed);
    cmd(`BDC_OP_WR_MATCH, {8'h00, v}, 16, 0, 0);
    chk_val(breakpoint_match, v);
    push({16'h0600, v});
    cmd(`BDC_OP_RD_MATCH, 24'h0, 0, 0, 16);
    cmd(`BDC_OP_ACK_ON, 24'h0, 0, 16, 0);
    chk_val(ack_enable, 32'h1);
    cmd(`BDC_OP_ACK_OFF, 24'h0, 0, 16, 0);
    chk_val(ack_enable, 32'h0);
    cmd(`BDC_OP_ACK_ON, 24'h0, 0, 16, 0);
    ack_m = 1'b1;
    b = $random(seed) & 8'h7F;
    ctrl_m = b & 8'hB8;
    cmd(`BDC_OP_WR_CTRL, {16'h0, b}, 8, 0, 0);
    chk_val(debug_status_control, ctrl_m);
    push({24'h060000, ss()});
    cmd(`BDC_OP_RD_STAT, 24'h0, 0, 0, 8);
    cmd(`BDC_OP_BGND, 24'h0, 0, 16, 0);
    ctrl_m = ctrl_m | 8'h80;
    cmd(`BDC_OP_WR_CTRL, {16'h0, ctrl_m}, 8, 0, 0);
    push(32'h05000000);
    cmd(`BDC_OP_BGND, 24'h0, 0, 16, 0);
    done("control");
    v = $random(seed);
    b = $random(seed);
    push({8'h01, v, b});
    cmd(`BDC_OP_WR_MEM, {v, b}, 24, 16, 0);
    push({24'h060000, b});
    cmd(`BDC_OP_RD_MEM, {8'h0, v}, 16, 16, 8);
    b = ~b;
    push({8'h01, v, b});
    push({24'h060000, ss()});
    cmd(`BDC_OP_WR_MEM_WS, {v, b}, 24, 16, 8);
    push({16'h0600, ss(), b});
    cmd(`BDC_OP_RD_MEM_WS, {8'h0, v}, 16, 16, 16);
    mem[v[7:0]] = b ^ 8'h5A;
    push({16'h0600, ss(), b ^ 8'h5A});
    cmd(`BDC_OP_RD_LAST, 24'h0, 0, 0, 16);
    done("memory");
    for (i = 0; i < 5; i = i + 1) begin
      b = rops[8 * i +: 8];
      len = (b[2:0] < 3'h3) ? 8 : 16;
      push({16'h0600, creg(b[2:0])});
      cmd(b, 24'h0, 0, 16, len);
      v = $random(seed);
      v = (len == 8) ? {8'h00, v[7:0]} : v;
      push({8'h02, 5'h00, b[2:0], v});
      cmd(b - 8'h20, {8'h00, v}, len, 16, 0);
    end
    push(32'h03000000);
    cmd(`BDC_OP_GO, 24'h0, 0, 16, 0);
    push(32'h04000000);
    cmd(`BDC_OP_STEP, 24'h0, 0, 16, 0);
    push(32'h03000000);
    cmd(`BDC_OP_TAG_GO, 24'h0, 0, 16, 0);
    v = cpu_hx + 16'h0001;
    mem[v[7:0]] = 8'hC3;
    push({13'h0040, 3'h4, v});
    push(32'h060000C3);
    cmd(`BDC_OP_RD_NEXT, 24'h0, 0, 16, 8);
    push({13'h0040, 3'h4, v});
    push({16'h0600, ss(), 8'hC3});
    cmd(`BDC_OP_RD_NEXT_WS, 24'h0, 0, 16, 16);
    b = $random(seed);
    push({13'h0040, 3'h4, v});
    push({8'h01, v, b});
    cmd(`BDC_OP_WR_NEXT, {16'h0, b}, 8, 16, 0);
    push({13'h0040, 3'h4, v});
    push({8'h01, v, ~b});
    push({24'h060000, ss()});
    cmd(`BDC_OP_WR_NEXT_WS, {16'h0, ~b}, 8, 16, 8);
    done("cpu");
    cpu_in_background = 1'b0;
    push(32'h06000000);
    cmd(`BDC_OP_RD_A, 24'h0, 0, 16, 8);
    cmd(`BDC_OP_GO, 24'h0, 0, 16, 0);
    pod.send({16'h0, `BDC_OP_WR_MEM}, 8);
    pod.send(24'h00ABCD, 10);
    pod.idle(600);
    push({24'h060000, ss()});
    cmd(`BDC_OP_RD_STAT, 24'h0, 0, 0, 8);
    done("abort");
    pod.sync(gap, len);
    chk_val(gap >= 'h10 && gap <= 'h14, 32'h1);
    chk_val(len, 32'h80);
    pod.idle(4);
    chk_val(debug_pin_oe, 32'h0);
    chk_val(exp_q.size(), 32'h0);
    done("sync");
    tally_and_finish;
  end
endmodule // test_bdc_command_serial_port
